/* src/dbsl_core.sv */
// Dynamic bus sizing sequencer: splits operands into port-width bus cycles
`timescale 1ns/1ns
`include "dbsl_regs.svh"

// Functional notes
// - Long at offset 3, 32-bit: 1 then 3
// - Odd word on 16-bit port: two cycles
// - Cycle counts follow size, alignment, port
// - Fetches are aligned long words
// - Both fetched words kept in holding register
// - Writes drive all four byte lanes
// - Size code gives bytes remaining, 00=four
// - Move largest count port accepts, carry rest
// - Four bytes at 01: 3 or 1
// - Aligned long: bytes 0-3 on lanes high-low
module dbsl_core
	import dbsl_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_ce,
	input wire logic i_req_valid,
	input wire dbsl_req_t i_req,
	output logic o_req_ready,
	output dbsl_bus_t o_bus,
	output logic o_bus_start,
	input wire logic i_port_ack_hi,
	input wire logic i_port_ack_lo,
	input wire logic [31:0] i_rdata,
	output logic o_done,
	output logic [31:0] o_rdata,
	output logic [31:0] o_hold
);
	// ==========================================================
	// State
	dbsl_state_t state_q;
	logic [31:0] addr_q;
	logic [1:0] rem_q;
	logic wr_q;
	logic if_q;
	logic [31:0] op_q;
	logic [31:0] acc_q;
	logic [31:0] bus_addr_q;
	logic [1:0] bus_size_q;
	logic bus_wr_q;
	logic [31:0] bus_data_q;
	logic start_q;
	logic ready_q;
	logic done_q;
	logic [31:0] rdata_q;
	logic [31:0] hold_q;

	// ==========================================================
	// Split arithmetic
	wire [1:0] ack = {i_port_ack_hi, i_port_ack_lo};
	wire acked = (ack != `DBSL_ACK_NONE);
	wire [2:0] rem_bytes = (rem_q == `DBSL_SIZ_FOUR) ? 3'd4 : {1'b0, rem_q};
	wire [1:0] a = addr_q[1:0];
	// Bytes the acknowledged port can take from this address
	wire [2:0] room_l = 3'd4 - {1'b0, a};
	wire [2:0] room_w = a[0] ? 3'd1 : 3'd2;
	wire [2:0] room = (ack == `DBSL_ACK_LONG) ? room_l : (ack == `DBSL_ACK_WORD) ? room_w : 3'd1;
	wire [2:0] moved = (room < rem_bytes) ? room : rem_bytes;
	wire [2:0] left = rem_bytes - moved;
	wire last = (left == 3'd0);
	wire [31:0] next_addr = addr_q + {29'h0, moved};
	wire [1:0] next_size = left[1:0];
	// Byte index of the operand that sits at the current address
	wire [1:0] first_idx = 2'(3'd4 - rem_bytes);

	// Operand bytes routed onto lanes, replicated so any port width finds them
	logic [31:0] wlanes;
	genvar g;
	generate
		for (g = 0; g < `DBSL_BYTE_LANES; g++) begin : g_lane
			// Lanes below the address serve narrow ports: a 16-bit port sees lanes 0-1, an 8-bit port lane 0
			wire up = (2'(g) >= a);
			wire mid = (g < `DBSL_BYTE_LANES / 2) && (2'(g) >= {1'b0, a[0]});
			wire [1:0] lane_ofs = up ? 2'(g) - a : mid ? 2'(g) - {1'b0, a[0]} : 2'h0;
			wire [1:0] bidx = first_idx + lane_ofs;
			assign wlanes[31-8*g -: `DBSL_LANE_BITS] = op_q[31-8*bidx -: `DBSL_LANE_BITS];
		end
	endgenerate

	// Incoming bytes land at their operand byte index, taken from the lane the port returned them on
	logic [31:0] acc_next;
	always_comb begin
		logic [1:0] lane;
		logic [1:0] bi;
		lane = 2'h0;
		bi = 2'h0;
		acc_next = acc_q;
		for (int k = 0; k < `DBSL_BYTE_LANES; k++) begin
			if (k < moved) begin
				lane = 2'(k) + ((ack == `DBSL_ACK_LONG) ? a : (ack == `DBSL_ACK_WORD) ? {1'b0, a[0]} : 2'h0);
				bi = first_idx + 2'(k);
				acc_next[31-8*bi -: `DBSL_LANE_BITS] = i_rdata[31-8*lane -: `DBSL_LANE_BITS];
			end
		end
	end

	// ==========================================================
	// Sequencer
	wire take = i_req_valid && ready_q;
	// Fetches are forced to the long-word boundary with a full size
	wire [31:0] req_addr = i_req.ifetch ? {i_req.addr[31:2], `DBSL_ADDR_LONG_MASK} : i_req.addr;
	wire [1:0] req_size = i_req.ifetch ? `DBSL_SIZ_FOUR : i_req.size;

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			state_q <= DBSL_IDLE;
			addr_q <= 32'h0000_0000;
			rem_q <= 2'h0;
			wr_q <= 1'b0;
			if_q <= 1'b0;
			op_q <= 32'h0000_0000;
			acc_q <= 32'h0000_0000;
			bus_addr_q <= 32'h0000_0000;
			bus_size_q <= 2'h0;
			bus_wr_q <= 1'b0;
			bus_data_q <= 32'h0000_0000;
			start_q <= 1'b0;
			ready_q <= 1'b0;
			done_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			hold_q <= 32'h0000_0000;
		end else if (i_ce) begin
			start_q <= 1'b0;
			done_q <= 1'b0;
			case (state_q)
				DBSL_IDLE: begin
					ready_q <= 1'b1;
					if (take) begin
						ready_q <= 1'b0;
						addr_q <= req_addr;
						rem_q <= req_size;
						wr_q <= i_req.write & ~i_req.ifetch;
						if_q <= i_req.ifetch;
						op_q <= i_req.wdata;
						acc_q <= 32'h0000_0000;
						state_q <= DBSL_RUN;
					end
				end
				DBSL_RUN: begin
					bus_addr_q <= addr_q;
					bus_size_q <= rem_q;
					bus_wr_q <= wr_q;
					bus_data_q <= wlanes;
					start_q <= 1'b1;
					state_q <= DBSL_WAIT;
				end
				DBSL_WAIT: begin
					if (acked) begin
						acc_q <= acc_next;
						addr_q <= next_addr;
						rem_q <= next_size;
						if (last) begin
							done_q <= 1'b1;
							rdata_q <= acc_next;
							// Full long word kept for the second instruction word
							if (if_q)
								hold_q <= acc_next;
							state_q <= DBSL_IDLE;
						end else begin
							state_q <= DBSL_RUN;
						end
					end
				end
				default: state_q <= DBSL_IDLE;
			endcase
		end
	end

	assign o_req_ready = ready_q;
	assign o_bus = '{addr: bus_addr_q, size: bus_size_q, write: bus_wr_q, data: bus_data_q};
	assign o_bus_start = start_q;
	assign o_done = done_q;
	assign o_rdata = rdata_q;
	assign o_hold = hold_q;

	// ==========================================================
	// Checks
	property p_fetch_aligned;
		@(posedge i_clk) disable iff (i_srst)
		(state_q == DBSL_RUN && if_q && rem_q == `DBSL_SIZ_FOUR) |-> (addr_q[1:0] == 2'h0);
	endproperty
	a_fetch_aligned: assert property (p_fetch_aligned) else $error("fetch not aligned");

	property p_long_word_split;
		@(posedge i_clk) disable iff (i_srst)
		(i_ce && state_q == DBSL_WAIT && rem_q == `DBSL_SIZ_FOUR && a == 2'h3 && ack == `DBSL_ACK_LONG)
		|=> (rem_q == `DBSL_SIZ_THREE && addr_q[1:0] == 2'h0);
	endproperty
	a_long_word_split: assert property (p_long_word_split) else $error("bad long split");

	property p_odd_word_16;
		@(posedge i_clk) disable iff (i_srst)
		(i_ce && state_q == DBSL_WAIT && rem_q == `DBSL_SIZ_TWO && a[0] && ack == `DBSL_ACK_WORD)
		|=> (rem_q == `DBSL_SIZ_ONE);
	endproperty
	a_odd_word_16: assert property (p_odd_word_16) else $error("odd word split wrong");

	property p_three_at_01;
		@(posedge i_clk) disable iff (i_srst)
		(state_q == DBSL_WAIT && rem_q == `DBSL_SIZ_FOUR && a == 2'h1 && ack == `DBSL_ACK_LONG) |-> (moved == 3'd3);
	endproperty
	a_three_at_01: assert property (p_three_at_01) else $error("long port at 01 not three");

	property p_narrow_at_01;
		@(posedge i_clk) disable iff (i_srst)
		(state_q == DBSL_WAIT && rem_q == `DBSL_SIZ_FOUR && a == 2'h1 && acked && ack != `DBSL_ACK_LONG)
		|-> (moved == 3'd1);
	endproperty
	a_narrow_at_01: assert property (p_narrow_at_01) else $error("narrow port at 01 not one");

	property p_bus_size_tracks;
		@(posedge i_clk) disable iff (i_srst)
		(i_ce && state_q == DBSL_RUN) |=> (o_bus.size == $past(rem_q) && o_bus_start);
	endproperty
	a_bus_size_tracks: assert property (p_bus_size_tracks) else $error("size code wrong");

	property p_addr_advance;
		@(posedge i_clk) disable iff (i_srst)
		(i_ce && state_q == DBSL_WAIT && acked && !last) |=> (addr_q == $past(addr_q) + 32'($past(moved)));
	endproperty
	a_addr_advance: assert property (p_addr_advance) else $error("address not advanced");

	property p_aligned_long_lanes;
		@(posedge i_clk) disable iff (i_srst)
		(i_ce && state_q == DBSL_RUN && wr_q && rem_q == `DBSL_SIZ_FOUR && a == 2'h0) |=> (o_bus.data == op_q);
	endproperty
	a_aligned_long_lanes: assert property (p_aligned_long_lanes) else $error("lane order wrong");

	property p_done_on_last;
		@(posedge i_clk) disable iff (i_srst)
		(i_ce && state_q == DBSL_WAIT && acked) |=> (o_done == $past(last));
	endproperty
	a_done_on_last: assert property (p_done_on_last) else $error("done mismatch");
endmodule // dbsl_core

/* src/dbsl_regs.svh */
// Constants for the dynamic bus sizing lane sequencer
`ifndef DBSL_REGS_SVH
`define DBSL_REGS_SVH
`define DBSL_SIZ_FOUR 2'h0
`define DBSL_SIZ_ONE 2'h1
`define DBSL_SIZ_TWO 2'h2
`define DBSL_SIZ_THREE 2'h3
`define DBSL_ACK_NONE 2'h0
`define DBSL_ACK_BYTE 2'h1
`define DBSL_ACK_WORD 2'h2
`define DBSL_ACK_LONG 2'h3
`define DBSL_ADDR_LONG_MASK 2'h0
`define DBSL_BYTE_LANES 4
`define DBSL_LANE_BITS 8
`endif

/* src/dbsl_pkg.sv */
// Types shared by the dynamic bus sizing lane sequencer
package dbsl_pkg;
	// Operand requested by the core
	typedef struct packed {
		logic [31:0] addr;
		logic [1:0] size;
		logic write;
		logic ifetch;
		logic [31:0] wdata;
	} dbsl_req_t;
	// One external bus cycle
	typedef struct packed {
		logic [31:0] addr;
		logic [1:0] size;
		logic write;
		logic [31:0] data;
	} dbsl_bus_t;
	typedef enum logic [1:0] {
		DBSL_IDLE,
		DBSL_RUN,
		DBSL_WAIT
	} dbsl_state_t;
endpackage

/* verification/dbsl_port.sv */
// Model of an external port of selectable width with a programmable acknowledge delay
`timescale 1ns/1ns
module dbsl_port
	import dbsl_pkg::*;
(
	input wire logic i_clk,
	input wire dbsl_bus_t i_bus,
	input wire logic i_start,
	input wire logic [2:0] i_width,
	input wire logic [1:0] i_dly,
	output logic o_ack_hi,
	output logic o_ack_lo,
	output logic [31:0] o_rdata
);
	logic [7:0] wmem [256];
	logic busy = 1'b0;
	logic [1:0] cnt = 2'h0;
	logic [31:0] base;
	logic [31:0] ad;
	logic [31:0] rem;
	initial {o_ack_hi, o_ack_lo, o_rdata} = '0;
	// ====================
	// Answer
	// Lanes outside the port toggle, so stale data never looks valid
	always @(posedge i_clk) begin
		{o_ack_hi, o_ack_lo} <= 2'b00;
		o_rdata <= ~o_rdata;
		if (busy && cnt == 2'h0) begin
			busy <= 1'b0;
			{o_ack_hi, o_ack_lo} <= (i_width == 3'd4) ? 2'b11 : (i_width == 3'd2) ? 2'b10 : 2'b01;
			base = i_bus.addr & ~({29'h0, i_width} - 32'h1);
			rem = (i_bus.size == 2'h0) ? 32'h4 : {30'h0, i_bus.size};
			for (int k = 0; k < 4; k++) begin
				ad = base + k;
				if (k < i_width) begin
					o_rdata[31-8*k -: 8] <= ad[7:0] * 8'h07 + 8'h03;
					if (i_bus.write && ad >= i_bus.addr && ad < i_bus.addr + rem)
						wmem[ad[7:0]] <= i_bus.data[31-8*k -: 8];
				end
			end
		end else if (busy)
			cnt <= cnt - 2'h1;
		if (i_start) begin
			busy <= 1'b1;
			cnt <= i_dly;
		end
	end
endmodule // dbsl_port

/* verification/dbsl_core_tb.sv */
// Self-checking bench for the bus sizing sequencer
`timescale 1ns/1ns
module dbsl_core_tb
	import dbsl_pkg::*;
;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic valid = 1'b0;
	dbsl_req_t req = '0;
	dbsl_bus_t bus;
	logic ready, start, done, ack_hi, ack_lo;
	logic [31:0] rdata, o_rd, hold;
	logic [2:0] width = 3'd4;
	logic [1:0] dly = 2'h0;
	logic ce = 1'b1;
	int fails = 0;
	int tests_run = 0;
	int seed = 4011;
	int cyc = 0;
	always #20 clk = ~clk;
	dbsl_core u_dbsl_core (.i_clk(clk), .i_srst(srst), .i_ce(ce), .i_req_valid(valid), .i_req(req),
		.o_req_ready(ready), .o_bus(bus), .o_bus_start(start), .i_port_ack_hi(ack_hi),
		.i_port_ack_lo(ack_lo), .i_rdata(rdata), .o_done(done), .o_rdata(o_rd), .o_hold(hold));
	dbsl_port u_dbsl_port (.i_clk(clk), .i_bus(bus), .i_start(start), .i_width(width), .i_dly(dly),
		.o_ack_hi(ack_hi), .o_ack_lo(ack_lo), .o_rdata(rdata));
	// ====================
	// Helpers
	function automatic logic [7:0] pat(input logic [31:0] a);
		return a[7:0] * 8'h07 + 8'h03;
	endfunction
	function automatic logic [31:0] room(input logic [31:0] a, input logic [2:0] w);
		return (w == 3'd4) ? 32'h4 - {30'h0, a[1:0]} : (w == 3'd2) ? 32'h2 - {31'h0, a[0]} : 32'h1;
	endfunction
	// Bus cycles per operand: one hex digit per alignment, ports 32, 16, 8 in turn
	function automatic logic [31:0] ncyc(input logic [1:0] sz, input logic [1:0] al, input logic [2:0] pw);
		logic [47:0] t;
		int i;
		t = (sz == 2'h2) ? 48'h1112_1212_2222 : 48'h1222_2323_4444;
		i = ((pw == 3'd4) ? 0 : (pw == 3'd2) ? 4 : 8) + al;
		return (sz == 2'h1) ? 32'h1 : {28'h0, t[47-4*i -: 4]};
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_sim();
		if (fails == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			end_sim();
		end
	end
	// ====================
	// One operand, checked cycle by cycle
	task automatic op(input logic [1:0] sz, input logic [31:0] a, input logic w, input logic f,
		input logic [2:0] pw);
		logic [31:0] ea, erem, n, e, m, nb;
		int k;
		int nc;
		width = pw;
		dly = 2'($random(seed));
		for (k = 0; k < 100 && ready !== 1'b1; k++)
			@(negedge clk);
		// A clock-enable gap while idle must lose nothing
		ce = 1'($random(seed));
		@(negedge clk);
		ce = 1'b1;
		req = '{a, sz, w, f, $random(seed)};
		valid = 1'b1;
		@(negedge clk);
		valid = 1'b0;
		ea = f ? {a[31:2], 2'b00} : a;
		erem = (f || sz == 2'h0) ? 32'h4 : {30'h0, sz};
		nb = erem;
		nc = 0;
		// Operands sit right-justified: the last byte is always in [7:0]
		for (int i = 0; i < 4; i++) begin
			e[31-8*i -: 8] = pat(ea + i - (32'h4 - nb));
			m[31-8*i -: 8] = (i >= 32'h4 - nb) ? 8'hff : 8'h00;
		end
		for (k = 0; k < 200 && done !== 1'b1; k++) begin
			@(negedge clk);
			if (start === 1'b1) begin
				nc++;
				chk("bus addr", bus.addr, ea);
				chk("bus size", {30'h0, bus.size}, {30'h0, erem[1:0]});
				chk("bus write", {31'h0, bus.write}, {31'h0, w});
				if (w && erem == 32'h4 && ea[1:0] == 2'b00)
					chk("write lanes", bus.data, req.wdata);
				n = (erem > room(ea, pw)) ? room(ea, pw) : erem;
				ea = ea + n;
				erem = erem - n;
			end
		end
		chk("bytes left", erem, 32'h0);
		if (f || sz != 2'h3)
			chk("cycles", nc, ncyc(f ? 2'h0 : sz, f ? 2'h0 : a[1:0], pw));
		if (f)
			chk("hold", hold, e);
		else if (!w)
			chk("read data", o_rd & m, e & m);
		else
			for (int i = 0; i < 4; i++)
				if (i < nb)
					chk("written byte", {24'h0, u_dbsl_port.wmem[8'(a + i)]},
						{24'h0, req.wdata[31-8*(4-nb+i) -: 8]});
	endtask
	initial begin
		repeat (6) @(negedge clk);
		srst = 1'b0;
		op(2'h0, 32'h103, 1'b1, 1'b0, 3'd4);
		op(2'h0, 32'h103, 1'b0, 1'b0, 3'd4);
		for (int p = 1; p <= 4; p = p * 2) begin
			op(2'h2, 32'h41, 1'b1, 1'b0, 3'(p));
			op(2'h2, 32'h41, 1'b0, 1'b0, 3'(p));
			op(2'h0, 32'h81, 1'b0, 1'b0, 3'(p));
			op(2'h0, 32'hc0, 1'b1, 1'b0, 3'(p));
			op(2'h1, 32'h23, 1'b0, 1'b1, 3'(p));
		end
		repeat (150) begin
			logic f;
			f = ($random(seed) & 7) == 0;
			op(2'($random(seed)), $random(seed), ~f & 1'($random(seed)), f, 3'd1 << (($random(seed) & 255) % 3));
		end
		end_sim();
	end
endmodule // dbsl_core_tb
